/* hw/cmf_clock_fanout.sv */
// clock selector with glitch-free gate and four-lane differential fanout
////////////////////////////////////////////////////////////////////////////////
module cmf_clock_fanout (
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   input  wire logic                          primary_clk_p,
   input  wire logic                          primary_clk_n,
   input  wire logic                          secondary_clk_p,
   input  wire logic                          secondary_clk_n,
   input  wire logic                          input_choice,
   input  wire logic                          input_choice_driven,
   input  wire logic                          output_gate_request,
   input  wire logic                          output_gate_request_driven,
   input  wire logic                          drive_enable,
   output      logic [cmf_pkg::NUM_LANES-1:0] fanout_out_true,
   output      logic [cmf_pkg::NUM_LANES-1:0] fanout_out_inv,
   output      logic [cmf_pkg::NUM_LANES-1:0] fanout_out_oe
);
   import cmf_pkg::*;

   typedef struct packed {
      logic                 lvl;
      logic                 gate;
      logic                 armed;
      logic [NUM_LANES-1:0] oe;
      logic [NUM_LANES-1:0] tru;
      logic [NUM_LANES-1:0] inv;
   } cmf_state_type;

   cmf_state_type     st_q;
   cmf_state_type     st_d;
   logic [1:0]        rst_pipe_q;
   logic              rst_sync_n;
   logic [SYNC_W-1:0] pins_raw;
   logic [SYNC_W-1:0] pins_s;
   logic              choice_eff;
   logic              gate_eff;
   logic              pri_lvl;
   logic              sec_lvl;
   logic              sel_lvl;
   logic              rise;
   logic              fall;
   logic              drv;

   ////////////////////////////////////////////////////////////////////////////////
   // reset release through two flops

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_pipe_q <= RST_PIPE_RST;
      end else begin
         rst_pipe_q <= {rst_pipe_q[0], 1'h1};
      end
   end
   assign rst_sync_n = rst_pipe_q[1];

   ////////////////////////////////////////////////////////////////////////////////
   // every pin, clocks included, is oversampled through two flops
   // limitation: an input clock level shorter than one clk cycle may be lost

   assign pins_raw = {drive_enable, output_gate_request_driven, output_gate_request,
                      input_choice_driven, input_choice, secondary_clk_n, secondary_clk_p,
                      primary_clk_n, primary_clk_p};

   cmf_sync u_sync (
      .clk   (clk),
      .rst_n (rst_sync_n),
      .din   (pins_raw),
      .dout  (pins_s)
   );

   always_comb begin
      // an undriven pin falls back to its pull resistor level
      choice_eff = pins_s[PIN_CHOICE_DR] ? pins_s[PIN_CHOICE] : CHOICE_OPEN;
      gate_eff   = pins_s[PIN_GATE_DR] ? pins_s[PIN_GATE] : GATE_OPEN;
      // a pair reads high only when true and inverted legs disagree that way
      pri_lvl    = pins_s[PIN_PRI_P] & ~pins_s[PIN_PRI_N];
      sec_lvl    = pins_s[PIN_SEC_P] & ~pins_s[PIN_SEC_N];
      sel_lvl    = choice_eff ? sec_lvl : pri_lvl;
      drv        = pins_s[PIN_DRIVE];
      rise       = sel_lvl & ~st_q.lvl;
      fall       = ~sel_lvl & st_q.lvl;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // gate flop and output lanes

   always_comb begin
      st_d     = st_q;
      st_d.lvl = sel_lvl;
      // edges come from the muxed level, so a select change is seen as the new clock
      if (gate_eff == st_q.gate) begin
         st_d.armed = 1'h0;
      end else if (fall && st_q.armed) begin
         st_d.gate  = gate_eff;
         st_d.armed = 1'h0;
      end else if (rise) begin
         st_d.armed = 1'h1;
      end
      st_d.oe = {NUM_LANES{drv}};
      if (!drv) begin
         st_d.tru = LANE_RST;
         st_d.inv = LANE_RST;
      end else if (!st_d.gate) begin
         st_d.tru = {NUM_LANES{1'h0}};
         st_d.inv = {NUM_LANES{1'h1}};
      end else begin
         st_d.tru = {NUM_LANES{sel_lvl}};
         st_d.inv = {NUM_LANES{~sel_lvl}};
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         st_q.lvl   <= LEVEL_RST;
         st_q.gate  <= GATE_RST;
         st_q.armed <= ARMED_RST;
         st_q.oe    <= LANE_RST;
         st_q.tru   <= LANE_RST;
         st_q.inv   <= LANE_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign fanout_out_true = st_q.tru;
   assign fanout_out_inv  = st_q.inv;
   assign fanout_out_oe   = st_q.oe;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   // antecedents use the synchronised pins, so pin timing is outside these checks

   AST_SELECT_SECONDARY: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (drv && st_d.gate && choice_eff) |=> (fanout_out_true == {NUM_LANES{$past(sec_lvl)}}))
      else $error("secondary clock not routed while selected");

   AST_CHOICE_OPEN: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (!pins_s[PIN_CHOICE_DR] && drv && st_d.gate)
         |=> (fanout_out_true == {NUM_LANES{$past(pri_lvl)}}))
      else $error("open choice pin did not select primary clock");

   AST_FLOAT: assert property (@(posedge clk) disable iff (!rst_sync_n)
      !drv |=> (fanout_out_oe == 4'h0 && fanout_out_true == 4'h0 && fanout_out_inv == 4'h0))
      else $error("outputs driven while drive enable low");

   AST_GATED_OFF: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (drv && !st_d.gate) |=> (fanout_out_oe == 4'hf && fanout_out_true == 4'h0 && fanout_out_inv == 4'hf))
      else $error("gated outputs not parked true low inverted high");

   AST_GATED_ON: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (drv && st_d.gate) |=> (fanout_out_inv == ~fanout_out_true && fanout_out_true == {NUM_LANES{$past(sel_lvl)}}))
      else $error("enabled outputs do not follow selected clock");

   AST_CHANGE_LOW: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (st_q.gate != st_d.gate) |-> !st_d.lvl)
      else $error("gate changed while selected clock high");

   AST_FALL_CAPTURE: assert property (@(posedge clk) disable iff (!rst_sync_n)
      $changed(st_q.gate) |-> ($past(st_q.lvl) && !st_q.lvl))
      else $error("gate flop moved away from a falling edge");

   AST_RISE_THEN_FALL: assert property (@(posedge clk) disable iff (!rst_sync_n)
      $changed(st_q.gate) |-> ($past(st_q.armed) && $past(st_q.gate, 2) != st_q.gate))
      else $error("gate switched without a prior rising edge");

   AST_LANES_EQUAL: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (fanout_out_true == {NUM_LANES{fanout_out_true[0]}}) && (fanout_out_inv == {NUM_LANES{fanout_out_inv[0]}}))
      else $error("fanout lanes disagree");

   AST_GATE_OPEN: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (!pins_s[PIN_GATE_DR] && st_q.gate) |=> st_q.gate)
      else $error("open gate request pin disabled the outputs");

   AST_PAIR_LOW: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (drv && st_d.gate && !choice_eff && !(pins_s[PIN_PRI_P] && !pins_s[PIN_PRI_N])) |=> (fanout_out_true == 4'h0))
      else $error("primary pair read high without true high and inverted low");

   AST_DRIVE_ON: assert property (@(posedge clk) disable iff (!rst_sync_n)
      drv |=> (fanout_out_oe == 4'hf))
      else $error("outputs not driven while drive enable high");

   AST_SWITCH_OUT_LOW: assert property (@(posedge clk) disable iff (!rst_sync_n)
      $changed(st_q.gate) |-> (fanout_out_true == 4'h0))
      else $error("gate switched while true outputs high");

   AST_GATE_ON_FALL_ONLY: assert property (@(posedge clk) disable iff (!rst_sync_n)
      !fall |=> $stable(st_q.gate))
      else $error("gate flop moved without a falling edge");

   AST_ARM_ON_RISE: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (gate_eff != st_q.gate && rise) |=> st_q.armed)
      else $error("pending gate change not armed by rising edge");

   AST_PENDING_DROP: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (gate_eff == st_q.gate) |=> !st_q.armed)
      else $error("gate change stayed armed after request returned");

   // main scenarios the bench should reach
   COV_ENABLE_SECONDARY: cover property (@(posedge clk) disable iff (!rst_sync_n)
      drv && choice_eff && st_q.gate && fanout_out_true[0]);
   COV_GATE_OFF: cover property (@(posedge clk) disable iff (!rst_sync_n)
      $fell(st_q.gate));
   COV_GATE_ON: cover property (@(posedge clk) disable iff (!rst_sync_n)
      $rose(st_q.gate));
   COV_FLOAT: cover property (@(posedge clk) disable iff (!rst_sync_n)
      $fell(fanout_out_oe[0]));
   COV_OPEN_CHOICE: cover property (@(posedge clk) disable iff (!rst_sync_n)
      !pins_s[PIN_CHOICE_DR] && drv && st_q.gate && fanout_out_true[0]);
endmodule : cmf_clock_fanout

/* hw/cmf_sync.sv */
// constants for the clock selector and the two-stage pin synchroniser
package cmf_pkg;
   localparam int unsigned NUM_LANES  = 4;
   localparam int unsigned SYNC_W     = 9;
   localparam int unsigned SYNC_DEPTH = 2;
   // bit positions inside the synchronised pin vector
   localparam int unsigned PIN_PRI_P     = 0;
   localparam int unsigned PIN_PRI_N     = 1;
   localparam int unsigned PIN_SEC_P     = 2;
   localparam int unsigned PIN_SEC_N     = 3;
   localparam int unsigned PIN_CHOICE    = 4;
   localparam int unsigned PIN_CHOICE_DR = 5;
   localparam int unsigned PIN_GATE      = 6;
   localparam int unsigned PIN_GATE_DR   = 7;
   localparam int unsigned PIN_DRIVE     = 8;
   // reset values
   localparam logic [8:0]  SYNC_RST   = 9'h000;
   localparam logic        GATE_RST   = 1'h1;
   localparam logic        LEVEL_RST  = 1'h0;
   localparam logic        ARMED_RST  = 1'h0;
   localparam logic [3:0]  LANE_RST   = 4'h0;
   localparam logic [1:0]  RST_PIPE_RST = 2'h0;
   // open pin defaults: choice pulled low, gate request pulled high
   localparam logic        CHOICE_OPEN = 1'h0;
   localparam logic        GATE_OPEN   = 1'h1;
endpackage : cmf_pkg

////////////////////////////////////////////////////////////////////////////////

module cmf_sync (
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic [cmf_pkg::SYNC_W-1:0] din,
   output      logic [cmf_pkg::SYNC_W-1:0] dout
);
   import cmf_pkg::*;

   // first stage is read only by the second stage
   logic [SYNC_W-1:0] meta_q;
   logic [SYNC_W-1:0] sync_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= SYNC_RST;
         sync_q <= SYNC_RST;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;
endmodule : cmf_sync

/* verification/cmf_clk_source.sv */
// behavioural differential clock source standing in for an external oscillator
////////////////////////////////////////////////////////////////////////////////
module cmf_clk_source #(
   parameter int HALF = 4
) (
   input  wire logic clk,
   output      logic clk_p,
   output      logic clk_n
);
   timeunit 1ns;
   timeprecision 1ps;
   int   cnt = 0;
   logic lvl_q = 1'b0;
   // moves on the falling edge so the block always samples a settled level
   always @(negedge clk) begin
      if (cnt == HALF - 1) begin
         cnt   <= 0;
         lvl_q <= ~lvl_q;
      end else begin
         cnt <= cnt + 1;
      end
   end
   assign clk_p = lvl_q;
   assign clk_n = ~lvl_q;
endmodule : cmf_clk_source

/* verification/cmf_clock_fanout_tb.sv */
// testbench for the clock selector with gated four-lane fanout
////////////////////////////////////////////////////////////////////////////////
module cmf_clock_fanout_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cmf_pkg::*;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       pp, pn, sp, sn, sel;
   logic       choice = 1'b0, choice_dr = 1'b1, gate = 1'b1, gate_dr = 1'b1, drive = 1'b1;
   logic [3:0] f_t, f_i, f_oe;
   logic [2:0] hist = 3'h0;
   logic       mon = 1'b0;
   int         half = 4;
   int         fails = 0, comparisons = 0, run = 0, rises = 0;
   always #2.5 clk = ~clk;
   cmf_clk_source #(.HALF(4)) u_pri (.clk(clk), .clk_p(pp), .clk_n(pn));
   cmf_clk_source #(.HALF(7)) u_sec (.clk(clk), .clk_p(sp), .clk_n(sn));
   cmf_clock_fanout u_dut (.clk(clk), .rst_n(rst_n), .primary_clk_p(pp), .primary_clk_n(pn),
      .secondary_clk_p(sp), .secondary_clk_n(sn), .input_choice(choice), .input_choice_driven(choice_dr),
      .output_gate_request(gate), .output_gate_request_driven(gate_dr), .drive_enable(drive),
      .fanout_out_true(f_t), .fanout_out_inv(f_i), .fanout_out_oe(f_oe));
   // pin-level view of the selected clock, delayed to match the pipeline
   assign sel = (choice & choice_dr) ? (sp & ~sn) : (pp & ~pn);
   always @(posedge clk) hist <= {hist[1:0], sel};
   task automatic check(string what, logic [3:0] seen, logic [3:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // a shortened high pulse on lane 0 would show as a run other than half
   always @(negedge clk) begin
      if (mon && f_t[0] === 1'b1) begin
         if (run == 0) rises++;
         run++;
      end else begin
         if (mon && run != 0) check("pulse_len", run[3:0], half[3:0]);
         run = 0;
      end
   end
   task automatic follow(string what, int n);
      repeat (n) begin
         @(negedge clk);
         check(what, f_t, {4{hist[2]}});
         check(what, f_i, ~{4{hist[2]}});
      end
   endtask : follow
   task automatic t_float();
      @(negedge clk);
      drive = 1'b0;
      gate = 1'b0;
      repeat (4) @(negedge clk);
      check("oe_off", f_oe, 4'h0);
      check("float_true", f_t, 4'h0);
      check("float_inv", f_i, 4'h0);
      drive = 1'b1;
      gate = 1'b1;
      repeat (12) @(negedge clk);
      check("oe_on", f_oe, 4'hf);
      $display("test float done");
   endtask : t_float
   task automatic t_select();
      follow("primary", 40);
      choice = 1'b1;
      repeat (4) @(negedge clk);
      follow("secondary", 40);
      choice_dr = 1'b0;
      repeat (4) @(negedge clk);
      follow("open_choice", 40);
      choice_dr = 1'b1;
      choice = 1'b0;
      repeat (6) @(negedge clk);
      $display("test select done");
   endtask : t_select
   task automatic t_gate();
      // start the pulse monitor between pulses so no partial run is measured
      while (f_t[0] !== 1'b0) @(negedge clk);
      mon = 1'b1;
      half = 4;
      rises = 0;
      gate = 1'b0;
      repeat (40) @(negedge clk);
      check("pulse_after_req", 4'(rises != 0), 4'h1);
      check("parked_true", f_t, 4'h0);
      check("parked_inv", f_i, 4'hf);
      choice = 1'b1;
      half = 7;
      repeat (20) @(negedge clk);
      check("parked_sec", f_t, 4'h0);
      check("parked_sec_inv", f_i, 4'hf);
      gate_dr = 1'b0;
      repeat (40) @(negedge clk);
      follow("open_gate", 40);
      mon = 1'b0;
      $display("test gate done");
   endtask : t_gate
   task automatic finish_test();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   initial begin
      #20000;
      fails++;
      finish_test();
   end
   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      repeat (8) @(negedge clk);
      t_float();
      t_select();
      t_gate();
      finish_test();
   end
endmodule : cmf_clock_fanout_tb
